// *** dv/pom_far_side.sv ***
/*
  far side of the port: peripherals owning alternate functions, and the pads.
  assumes the design's override and pad ports and one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pom_far_side (
  // clock
  input  wire logic       clk,
  // peripheral requests and the overrides they make
  input  wire logic [7:0] own,
  input  wire logic [7:0] req_en [4],
  input  wire logic [7:0] req_val [4],
  output logic      [7:0] ovr_en [4],
  output logic      [7:0] ovr_val [4],
  // pads
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_lvl,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe_n,
  input  wire logic [7:0] pad_pullup_en,
  output logic      [7:0] pad_in
);
  // an undriven pad wanders, so no test passes by luck
  logic [7:0] float_q = 8'h55;

  always_ff @(posedge clk) float_q <= ~float_q;

  // unowned pins see inactive overrides
  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      ovr_en[k]  = req_en[k] & own;
      ovr_val[k] = req_val[k] & own;
    end
  end

  // design driver wins, then external driver, then pull-up
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pad_in[i] = !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_lvl[i] : pad_pullup_en[i] ? 1'b1 : float_q[i];
  end
endmodule
`default_nettype wire

// *** dv/test_port_pin_override_mux.sv ***
/*
  self-checking bench for the port pin override mux: register tasks,
  overrides, pull-ups, sleep clamp, wake flags and reset.
  assumes pom_far_side stands for peripherals and pads.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pom_cfg.svh"

module test_port_pin_override_mux;
  logic        clk, sys_rst, clk_en, reg_wr, reg_rd;
  logic [1:0]  reg_addr;
  logic [2:0]  sleep_mode;
  logic [3:0]  misc_bits;
  logic [15:0] sense;
  logic [7:0]  reg_wdata, reg_rdata, rd_q, pin_en, req_ie, clr, flag;
  logic [7:0]  own, ext_en, ext_lvl, an_out, an_oe_n, alt_din, ai, pad_in;
  logic [7:0]  pad_out, pad_oe_n, pad_pu, pad_ao, pad_aoe_n, exp_v;
  logic [7:0]  req_en [4];
  logic [7:0]  req_val [4];
  logic [7:0]  ovr_en [4];
  logic [7:0]  ovr_val [4];
  int          n_fail, samples_checked, cycles;

  pom_port_pin_override_mux u_dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
    .ext_int_pin_en(pin_en), .ext_int_req_en(req_ie), .ext_int_sense(sense),
    .ext_int_flag_clr(clr), .ext_int_flag_q(flag),
    .pullup_override_en(ovr_en[0]), .pullup_override_val(ovr_val[0]),
    .dir_override_en(ovr_en[1]), .dir_override_val(ovr_val[1]),
    .value_override_en(ovr_en[2]), .value_override_val(ovr_val[2]),
    .in_enable_override_en(ovr_en[3]), .in_enable_override_val(ovr_val[3]),
    .alt_digital_in(alt_din), .alt_analog_in(ai), .alt_analog_out(an_out), .alt_analog_oe_n(an_oe_n),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pu),
    .pad_analog_out(pad_ao), .pad_analog_oe_n(pad_aoe_n),
    .timer_sync_mode(misc_bits[3]), .comparator_mux_enable(misc_bits[2]),
    .prescaler_reset_a(misc_bits[1]), .prescaler_reset_b(misc_bits[0])
  );

  pom_far_side u_far (
    .clk(clk), .own(own), .req_en(req_en), .req_val(req_val), .ovr_en(ovr_en), .ovr_val(ovr_val),
    .ext_en(ext_en), .ext_lvl(ext_lvl), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup_en(pad_pu), .pad_in(pad_in)
  );

  // free running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard, well above the hundred or so cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      $display("MISMATCH timeout expected finish seen hang");
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // main sequence
  initial
  begin
    {sys_rst, clk_en} = 2'b11;
    {reg_wr, reg_rd, reg_addr, reg_wdata, sleep_mode} = '0;
    {pin_en, req_ie, clr, sense, own, an_out, an_oe_n, ext_lvl} = '0;
    ext_en = 8'hff;
    for (int k = 0; k < 4; k++) {req_en[k], req_val[k]} = '0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    reg_read(`POM_OFF_MISC, rd_q); chk("misc reset", 8'h00, rd_q);
    wait_cyc(1); chk("rdata idle", 8'h00, reg_rdata);
    reg_write(`POM_OFF_MISC, 8'hff); chk("misc outs", 8'h0f, {4'h0, misc_bits});
    reg_read(`POM_OFF_MISC, rd_q); chk("misc rw", 8'h8f, rd_q);
    reg_write(`POM_OFF_OUT, 8'hff); chk("pull global off", 8'h00, pad_pu);
    reg_write(`POM_OFF_MISC, 8'h00); chk("pull input high", 8'hff, pad_pu);
    reg_write(`POM_OFF_DIR, 8'h0f); chk("pull outputs off", 8'hf0, pad_pu);
    chk("driver from dir", 8'hf0, pad_oe_n);
    chk("driven level", 8'h0f, pad_out & ~pad_oe_n);
    reg_write(`POM_OFF_PIN, 8'haa);
    @(posedge clk) ext_lvl <= 8'h5a;
    wait_cyc(4); chk("alt din", 8'h5f, alt_din); chk("analog in", 8'h5f, ai);
    reg_read(`POM_OFF_PIN, rd_q); chk("pin read", 8'h5f, rd_q);
    // pull-up, direction and value overrides in one cycle, checked before the next edge
    @(posedge clk);
    own <= 8'hff;
    {req_en[0], req_val[0], req_en[1], req_val[1], req_en[2], req_val[2]} <= 48'h0f05_f030_0f0a;
    {an_out, an_oe_n} <= 16'h3cc3;
    #1 chk("pull override", 8'hf5, pad_pu);
    chk("dir override", 8'hc0, pad_oe_n);
    chk("value override", 8'h3a, pad_out & 8'h3f);
    chk("analog pass", 8'h3c, pad_ao); chk("analog oe", 8'hc3, pad_aoe_n);
    @(posedge clk) own <= 8'h0f;
    #1 chk("unowned pins", 8'hf0, pad_oe_n);
    // sleep clamp over every mode
    reg_write(`POM_OFF_DIR, 8'h00);
    @(posedge clk);
    {own, req_en[0], req_en[1], req_en[2], req_en[3], req_val[3]} <= 48'h0400_0000_0404;
    {ext_lvl, pin_en, req_ie} <= 24'hff_03_01;
    for (int m = 0; m < 7; m++)
    begin
      @(posedge clk) sleep_mode <= 3'(m);
      exp_v = 3'(m) inside {pom_pkg::POM_MODE_PWR_DOWN, pom_pkg::POM_MODE_PWR_SAVE,
                            pom_pkg::POM_MODE_STANDBY, pom_pkg::POM_MODE_EXT_STBY} ? 8'h05 : 8'hff;
      wait_cyc(4); chk("clamp din", exp_v, alt_din);
      reg_read(`POM_OFF_PIN, rd_q); chk("clamp pin", exp_v, rd_q);
    end
    @(posedge clk) sleep_mode <= 3'h0;
    wait_cyc(4); chk("no wake flag", 8'h00, flag);
    // wake: pin 1 high with edge sense flags, pin 3 low does not, pin 0 enabled does not
    @(posedge clk) {pin_en, req_ie, sense, ext_lvl} <= 40'h0b_01_008f_f7;
    @(posedge clk) sleep_mode <= pom_pkg::POM_MODE_PWR_DOWN;
    wait_cyc(3);
    @(posedge clk) sleep_mode <= pom_pkg::POM_MODE_ACTIVE;
    wait_cyc(3); chk("wake flag", 8'h02, flag);
    @(posedge clk) clr <= 8'hff;
    @(posedge clk) clr <= 8'h00;
    #1 chk("flag clear", 8'h00, flag);
    // reset in mid-run with drivers and pull-ups on
    @(posedge clk) own <= 8'h00;
    reg_write(`POM_OFF_OUT, 8'hff);
    reg_write(`POM_OFF_DIR, 8'h0f);
    // clock enable low: the write strobe must be dropped
    @(posedge clk) clk_en <= 1'b0;
    reg_write(`POM_OFF_DIR, 8'hff); chk("frozen dir", 8'hf0, pad_oe_n);
    @(posedge clk) clk_en <= 1'b1;
    @(posedge clk) sys_rst <= 1'b1;
    #1 chk("reset tristate", 8'hff, pad_oe_n);
    chk("reset pull off", 8'h00, pad_pu);
    wait_cyc(2);
    @(posedge clk) sys_rst <= 1'b0;
    reg_read(`POM_OFF_DIR, rd_q); chk("dir reset", 8'h00, rd_q);
    give_verdict();
  end
endmodule
`default_nettype wire

// *** hw/pom_cfg.svh ***
/*
  offsets, field positions, reset values and widths for the port pin override mux.
  assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef POM_CFG_SVH
`define POM_CFG_SVH

// port shape
`define POM_PINS          8
`define POM_ADDR_W        2

// register offsets on the plain register port
`define POM_OFF_DIR       2'h0
`define POM_OFF_OUT       2'h1
`define POM_OFF_PIN       2'h2
`define POM_OFF_MISC      2'h3

// misc_io_control field positions
`define POM_MISC_SYNCMODE 7
`define POM_MISC_CMP_MUX  3
`define POM_MISC_PU_DIS   2
`define POM_MISC_PSRA     1
`define POM_MISC_PSRB     0

// reset values
`define POM_DIR_RST       8'h00
`define POM_OUT_RST       8'h00
`define POM_MISC_RST      8'h00
// bits 6..4 read as zero, everything else is writable storage
`define POM_MISC_WMASK    8'h8f

// external interrupt sense code: low level; any other code is an edge sense
`define POM_SENSE_LEVEL   2'h0

`endif

// *** hw/pom_pkg.sv ***
/*
  types for the port pin override mux: sleep controller mode codes and
  the clamp tracking state.
  assumes the sleep controller drives its mode with these codes.
*/
package pom_pkg;

  // sleep controller mode codes
  typedef enum logic [2:0] {
    POM_MODE_ACTIVE   = 3'h0,
    POM_MODE_IDLE     = 3'h1,
    POM_MODE_ADC_NR   = 3'h2,
    POM_MODE_PWR_DOWN = 3'h3,
    POM_MODE_PWR_SAVE = 3'h4,
    POM_MODE_STANDBY  = 3'h5,
    POM_MODE_EXT_STBY = 3'h6
  } pom_sleep_e;

  // clamp tracking state, one-hot
  typedef enum logic [1:0] {
    POM_ST_AWAKE   = 2'b01,
    POM_ST_CLAMPED = 2'b10
  } pom_state_e;

endpackage

// *** hw/pom_port_pin_override_mux.sv ***
/*
  one 8-pin general purpose port with per-pin alternate function overrides,
  sleep input clamping, external interrupt wake flags and the shared
  misc_io_control register holding the global pull-up disable.
  assumes pads resolve level from pad_out/pad_oe_n/pad_pullup_en, peripherals
  drive their own overrides (inactive where unused), and a plain register port.
*/
// Design decisions made here: the address map and the plain strobed port.
//
// Behaviour
// - clamp digital inputs to ground in power-down, power-save, standby, extended standby.
// - no clamp on enabled external interrupt pins; clamp again when request disabled.
// - on wake set interrupt flag if pin high, edge sense, interrupt disabled.
// - internal pull-ups are off while reset is active.
// - without pull-up override, pull-up on only for direction 0, output 1, disable 0.
// - with pull-up override, pull-up follows the override value alone.
// - without direction override, output driver follows the direction bit.
// - with direction override, output driver follows the override value alone.
// - driven value is output bit, or value override when its enable is high.
// - with value override enabled, driven value equals override value.
// - without input-enable override, input enabled when awake, off in clamping modes.
// - with input-enable override, input enable follows the override value.
// - alternate digital input taken after gate, before synchroniser; receiver syncs it.
// - analog connection wired straight to the pad, bypassing digital logic.
// - port strobes shared across pins; clock, clamp, pull-up disable shared; overrides per pin.
// - misc_io_control is 8 bits, reset zero, bit 2 pull-up disable, 6..4 read zero.
// - global pull-up disable set turns off every pull-up not under pull-up override.
// - direction one means output driven from output bit; zero means input.
// - all pins tri-stated while reset is active, even without a clock.
`timescale 1ns/1ps
`default_nettype none
`include "pom_cfg.svh"

module pom_port_pin_override_mux (
  // clock, reset, enable
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     clk_en,
  // register port
  input  wire logic [`POM_ADDR_W-1:0]   reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [7:0]               reg_rdata,
  // sleep controller
  input  wire logic [2:0]               sleep_mode,
  // external interrupt configuration, per pin
  input  wire logic [`POM_PINS-1:0]     ext_int_pin_en,
  input  wire logic [`POM_PINS-1:0]     ext_int_req_en,
  input  wire logic [2*`POM_PINS-1:0]   ext_int_sense,
  input  wire logic [`POM_PINS-1:0]     ext_int_flag_clr,
  output logic      [`POM_PINS-1:0]     ext_int_flag_q,
  // alternate function overrides, per pin
  input  wire logic [`POM_PINS-1:0]     pullup_override_en,
  input  wire logic [`POM_PINS-1:0]     pullup_override_val,
  input  wire logic [`POM_PINS-1:0]     dir_override_en,
  input  wire logic [`POM_PINS-1:0]     dir_override_val,
  input  wire logic [`POM_PINS-1:0]     value_override_en,
  input  wire logic [`POM_PINS-1:0]     value_override_val,
  input  wire logic [`POM_PINS-1:0]     in_enable_override_en,
  input  wire logic [`POM_PINS-1:0]     in_enable_override_val,
  output logic      [`POM_PINS-1:0]     alt_digital_in,
  // analog connection to alternate functions
  output logic      [`POM_PINS-1:0]     alt_analog_in,
  input  wire logic [`POM_PINS-1:0]     alt_analog_out,
  input  wire logic [`POM_PINS-1:0]     alt_analog_oe_n,
  // pads
  input  wire logic [`POM_PINS-1:0]     pad_in,
  output logic      [`POM_PINS-1:0]     pad_out,
  output logic      [`POM_PINS-1:0]     pad_oe_n,
  output logic      [`POM_PINS-1:0]     pad_pullup_en,
  output logic      [`POM_PINS-1:0]     pad_analog_out,
  output logic      [`POM_PINS-1:0]     pad_analog_oe_n,
  // misc_io_control bits owned by other units
  output logic                          timer_sync_mode,
  output logic                          comparator_mux_enable,
  output logic                          prescaler_reset_a,
  output logic                          prescaler_reset_b
);

  // clamping sleep modes, used for the clamp and by checks
  function automatic logic is_clamping(input logic [2:0] mode);
    case (pom_pkg::pom_sleep_e'(mode))
      pom_pkg::POM_MODE_PWR_DOWN,
      pom_pkg::POM_MODE_PWR_SAVE,
      pom_pkg::POM_MODE_STANDBY,
      pom_pkg::POM_MODE_EXT_STBY: is_clamping = 1'b1;
      default:                    is_clamping = 1'b0;
    endcase
  endfunction

  logic [`POM_PINS-1:0] pin_direction_bit;
  logic [`POM_PINS-1:0] pin_output_bit;
  logic [`POM_PINS-1:0] pin_input_bit;
  logic [7:0]           misc_io_control;
  logic                 global_pullup_disable;
  logic                 sleep_clamp;
  logic [`POM_PINS-1:0] clamp_pin;
  logic [`POM_PINS-1:0] in_enable;
  logic [`POM_PINS-1:0] gated_in;
  logic [`POM_PINS-1:0] raw_level;
  logic [`POM_PINS-1:0] drv_en;
  logic [`POM_PINS-1:0] wake_set;
  logic                 wake;
  pom_pkg::pom_state_e  state_q;
  pom_pkg::pom_state_e  state_d;

  // port strobes, shared by every pin of the port
  logic wr_dir;
  logic wr_out;
  logic wr_misc;
  assign wr_dir  = reg_wr && (reg_addr == `POM_OFF_DIR);
  assign wr_out  = reg_wr && (reg_addr == `POM_OFF_OUT);
  assign wr_misc = reg_wr && (reg_addr == `POM_OFF_MISC);

  assign global_pullup_disable = misc_io_control[`POM_MISC_PU_DIS];
  assign sleep_clamp           = is_clamping(sleep_mode);

  // direction and output registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_direction_bit <= `POM_DIR_RST;
      pin_output_bit    <= `POM_OUT_RST;
    end
    else if (clk_en)
    begin
      if (wr_dir)
        pin_direction_bit <= reg_wdata;
      if (wr_out)
        pin_output_bit <= reg_wdata;
    end
  end

  // shared control register; bits 6..4 never store
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      misc_io_control <= `POM_MISC_RST;
    else if (clk_en && wr_misc)
      misc_io_control <= reg_wdata & `POM_MISC_WMASK;
  end

  // bits for other units, straight from the register
  assign timer_sync_mode       = misc_io_control[`POM_MISC_SYNCMODE];
  assign comparator_mux_enable = misc_io_control[`POM_MISC_CMP_MUX];
  assign prescaler_reset_a     = misc_io_control[`POM_MISC_PSRA];
  assign prescaler_reset_b     = misc_io_control[`POM_MISC_PSRB];

  // per-pin override muxing; combinational so peripherals see no extra latency
  genvar g;
  generate
    for (g = 0; g < `POM_PINS; g++)
    begin : g_pin
      // enabled external interrupt pins escape the clamp
      assign clamp_pin[g] = sleep_clamp && !(ext_int_pin_en[g] && ext_int_req_en[g]);
      assign in_enable[g] = in_enable_override_en[g] ? in_enable_override_val[g]
                                                     : !clamp_pin[g];
      assign gated_in[g]  = pad_in[g] && in_enable[g];
      assign alt_digital_in[g] = gated_in[g];
      assign drv_en[g]    = dir_override_en[g] ? dir_override_val[g]
                                               : pin_direction_bit[g];
      // reset forces tri-state without waiting for an edge
      assign pad_oe_n[g]  = sys_rst || !drv_en[g];
      assign pad_out[g]   = value_override_en[g] ? value_override_val[g]
                                                 : pin_output_bit[g];
      // pull-up also dropped in reset, so unused pins float until software runs
      assign pad_pullup_en[g] = !sys_rst &&
        (pullup_override_en[g] ? pullup_override_val[g]
                               : (!pin_direction_bit[g] && pin_output_bit[g]
                                  && !global_pullup_disable));
      // analog path is a plain wire, no gating at all
      assign alt_analog_in[g]   = pad_in[g];
      assign pad_analog_out[g]  = alt_analog_out[g];
      assign pad_analog_oe_n[g] = alt_analog_oe_n[g];
    end
  endgenerate

  // pin input register behind the gate, so clamped pins read zero
  pom_sync2 #(
    .W(`POM_PINS)
  ) u_pin_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in (gated_in),
    .sync_out (pin_input_bit)
  );

  // ungated pad level for the wake check
  pom_sync2 #(
    .W(`POM_PINS)
  ) u_raw_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in (pad_in),
    .sync_out (raw_level)
  );

  // clamp tracking state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      pom_pkg::POM_ST_AWAKE:   if (sleep_clamp) state_d = pom_pkg::POM_ST_CLAMPED;
      pom_pkg::POM_ST_CLAMPED: if (!sleep_clamp) state_d = pom_pkg::POM_ST_AWAKE;
      default:                 state_d = pom_pkg::POM_ST_AWAKE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_q <= pom_pkg::POM_ST_AWAKE;
    else if (clk_en)
      state_q <= state_d;
  end

  // leaving a clamping mode is the moment the clamp releases
  assign wake = (state_q == pom_pkg::POM_ST_CLAMPED) && !sleep_clamp;

  // wake flag: the released clamp looks like an edge to a disabled interrupt
  generate
    for (g = 0; g < `POM_PINS; g++)
    begin : g_wake
      assign wake_set[g] = wake && ext_int_pin_en[g] && !ext_int_req_en[g] && raw_level[g]
                           && (ext_int_sense[2*g +: 2] != `POM_SENSE_LEVEL);
    end
  endgenerate

  // set beats clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ext_int_flag_q <= '0;
    else if (clk_en)
      ext_int_flag_q <= (ext_int_flag_q & ~ext_int_flag_clr) | wake_set;
  end

  // read data stands for exactly one cycle after the read strobe
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (clk_en)
    begin
      if (reg_rd)
      begin
        case (reg_addr)
          `POM_OFF_DIR:  reg_rdata <= pin_direction_bit;
          `POM_OFF_OUT:  reg_rdata <= pin_output_bit;
          `POM_OFF_PIN:  reg_rdata <= pin_input_bit;
          `POM_OFF_MISC: reg_rdata <= misc_io_control;
          default:       reg_rdata <= 8'h00;
        endcase
      end
      else
        reg_rdata <= 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // three enabled edges flush both stages of the input synchroniser
  a_clamp_zero_read: assert property (
    (clk_en && !in_enable[7])[*3] |-> !pin_input_bit[7])
    else $error("clamped pins did not read as zero");

  a_int_pin_escape: assert property (
    (sleep_clamp && ext_int_pin_en[0] && ext_int_req_en[0] && !in_enable_override_en[0])
      |-> (alt_digital_in[0] == pad_in[0]))
    else $error("enabled interrupt pin was clamped");

  a_clamp_ground: assert property (
    (sleep_clamp && !(ext_int_pin_en[1] && ext_int_req_en[1]) && !in_enable_override_en[1])
      |-> !alt_digital_in[1])
    else $error("digital input not clamped in deep sleep");

  a_wake_flag_set: assert property (
    (clk_en && wake && ext_int_pin_en[1] && !ext_int_req_en[1] && raw_level[1]
      && (ext_int_sense[3:2] != `POM_SENSE_LEVEL)) |=> ext_int_flag_q[1])
    else $error("wake flag not set");

  a_flag_no_spurious: assert property (
    (clk_en && !ext_int_flag_q[2] && !wake) |=> !ext_int_flag_q[2])
    else $error("interrupt flag set without wake");

  a_pullup_table: assert property (
    (!pullup_override_en[3]) |->
      (pad_pullup_en[3] == (!pin_direction_bit[3] && pin_output_bit[3] && !global_pullup_disable)))
    else $error("pull-up not per direction, output and disable");

  a_pud_kills_pull: assert property (
    (global_pullup_disable && (pullup_override_en == '0)) |-> (pad_pullup_en == '0))
    else $error("pull-up on while globally disabled");

  a_dir_override: assert property (
    dir_override_en[4] |-> (pad_oe_n[4] == !dir_override_val[4]))
    else $error("direction override ignored");

  a_value_override: assert property (
    value_override_en[2] |-> (pad_out[2] == value_override_val[2]))
    else $error("value override ignored");

  a_pud_write: assert property (
    (clk_en && wr_misc) |=> (global_pullup_disable == $past(reg_wdata[`POM_MISC_PU_DIS]))
                            && (misc_io_control[6:4] == 3'h0))
    else $error("misc_io_control write wrong");

  a_read_one_cycle: assert property (
    (clk_en && !reg_rd) |=> (reg_rdata == 8'h00))
    else $error("read data stood without a read");

  // override paths, one watched pin per kind; analog wire checked on all pins
  a_pullup_ovr_val: assert property (
    pullup_override_en[0] |-> (pad_pullup_en[0] == pullup_override_val[0]))
    else $error("pull-up override value ignored");

  a_dir_from_bit: assert property (
    !dir_override_en[6] |-> (pad_oe_n[6] == !pin_direction_bit[6]))
    else $error("driver enable not from direction bit");

  a_value_from_bit: assert property (
    !value_override_en[0] |-> (pad_out[0] == pin_output_bit[0]))
    else $error("driven value not from output bit");

  a_in_enable_ovr: assert property (
    in_enable_override_en[2] |-> (alt_digital_in[2] == (pad_in[2] && in_enable_override_val[2])))
    else $error("input enable override ignored");

  a_analog_wire: assert property (
    (pad_analog_out == alt_analog_out) && (pad_analog_oe_n == alt_analog_oe_n) && (alt_analog_in == pad_in))
    else $error("analog path not a straight wire");

  // sticky until cleared, so software never misses a wake edge
  a_flag_sticky: assert property (
    (clk_en && ext_int_flag_q[1] && !ext_int_flag_clr[1]) |=> ext_int_flag_q[1])
    else $error("wake flag lost without a clear");

endmodule

`default_nettype wire

// *** hw/pom_sync2.sv ***
/*
  two flip-flop synchroniser for a vector of pad levels.
  assumes a single clock; the first stage is read only by the second.
*/
`timescale 1ns/1ps
`default_nettype none

module pom_sync2 #(
  parameter int W = 8
) (
  // clock and control
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  // data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // two stages, held while the clock enable is low
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else if (clk_en)
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire
